// ---- pfr_pkg.sv ----
package pfr_pkg;
  localparam int MCLK_PERIOD_NS = 50;
  localparam int STAB_TIME_NS = 50000;
  localparam int STAB_CYCLES = STAB_TIME_NS / MCLK_PERIOD_NS;
  localparam int STAB_W = 11;
  localparam int CNT_W = 16;
  localparam logic [15:0] TICK_PER_RST = 16'h0008;
  localparam int NUM_OUT = 3;
  localparam int SY_REF = 0;
  localparam int SY_FB = 1;
  localparam int SY_SEL = 2;
  localparam int SY_OEN = 3;
  localparam int SY_BYP = 4;
  localparam int SY_CLR = 5;
  localparam int SY_W = 6;
  localparam logic [5:0] SYNC_RST = 6'h08;

  typedef enum logic [0:0] {
    PFR_ACQUIRE = 1'b0,
    PFR_LOCKED = 1'b1
  } pfr_lock_t;

  function automatic logic pfr_rise(input logic cur, input logic prev);
    pfr_rise = cur & ~prev;
  endfunction
endpackage

// ---- pfr_divider.sv ----
`timescale 1ns/1ps
module pfr_divider (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  output logic div2,
  output logic div4
);
  logic div2_r;
  logic div2_nxt;
  logic div4_r;
  logic div4_nxt;

  always_comb begin
    div2_nxt = div2_r;
    div4_nxt = div4_r;
    if (clear) begin
      div2_nxt = 1'b0;
      div4_nxt = 1'b0;
    end else if (tick) begin
      div2_nxt = ~div2_r;
      if (div2_r) begin
        div4_nxt = ~div4_r;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div2_r <= 1'b0;
      div4_r <= 1'b0;
    end else begin
      div2_r <= div2_nxt;
      div4_r <= div4_nxt;
    end
  end

  assign div2 = div2_r;
  assign div4 = div4_r;

  half_duty_a: assert property (@(posedge mclk) disable iff (rst)
    (!$past(clear) && $changed(div2_r)) |-> $past(tick));
  quarter_duty_a: assert property (@(posedge mclk) disable iff (rst)
    $changed(div4_r) |-> ($past(clear) || ($past(tick) && $past(div2_r))));
endmodule

// ---- pfr_clock_fanout.sv ----
`timescale 1ns/1ps
module pfr_clock_fanout (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reference_clock_in,
  input wire logic feedback_clock_in,
  input wire logic ratio_select,
  input wire logic output_enable_n,
  input wire logic loop_bypass,
  input wire logic factory_clear_pin,
  output logic [2:0] bank_one_clock_outputs,
  output logic [2:0] bank_one_clock_oe,
  output logic [2:0] bank_two_clock_outputs,
  output logic [2:0] bank_two_clock_oe,
  output logic phase_locked
);
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic [5:0] prev_r;
  logic ref_rise;
  logic fb_rise;
  logic restart;
  logic tick;
  logic div2;
  logic div4;
  logic clr;
  logic [15:0] ref_cnt_r;
  logic [15:0] ref_cnt_nxt;
  logic [15:0] ref_per_r;
  logic [15:0] ref_per_nxt;
  logic [15:0] fb_cnt_r;
  logic [15:0] fb_cnt_nxt;
  logic [15:0] tick_cnt_r;
  logic [15:0] tick_cnt_nxt;
  logic [15:0] tick_per_r;
  logic [15:0] tick_per_nxt;
  logic [10:0] stab_r;
  logic [10:0] stab_nxt;
  logic refdiv_r;
  logic refdiv_nxt;
  logic aligned_r;
  logic aligned_nxt;
  pfr_pkg::pfr_lock_t state_r;
  pfr_pkg::pfr_lock_t state_nxt;
  logic [2:0] b1_r;
  logic [2:0] b1_nxt;
  logic [2:0] b2_r;
  logic [2:0] b2_nxt;
  logic [2:0] oe_r;
  logic [2:0] oe_nxt;

  // Every pin but rst is foreign to mclk and passes two flops first; rst acts on the flops directly.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= pfr_pkg::SYNC_RST;
      s2_r <= pfr_pkg::SYNC_RST;
      prev_r <= pfr_pkg::SYNC_RST;
    end else begin
      s1_r <= {factory_clear_pin, loop_bypass, output_enable_n, ratio_select,
               feedback_clock_in, reference_clock_in};
      s2_r <= s1_r;
      prev_r <= s2_r;
    end
  end

  assign ref_rise = pfr_pkg::pfr_rise(s2_r[pfr_pkg::SY_REF], prev_r[pfr_pkg::SY_REF]);
  assign fb_rise = pfr_pkg::pfr_rise(s2_r[pfr_pkg::SY_FB], prev_r[pfr_pkg::SY_FB]);
  assign clr = s2_r[pfr_pkg::SY_CLR];
  assign tick = (tick_cnt_r >= tick_per_r - 16'h0001);

  always_comb begin
    restart = pfr_pkg::pfr_rise(prev_r[pfr_pkg::SY_OEN], s2_r[pfr_pkg::SY_OEN]);
    restart = restart | (s2_r[pfr_pkg::SY_SEL] ^ prev_r[pfr_pkg::SY_SEL]);
    restart = restart | pfr_pkg::pfr_rise(prev_r[pfr_pkg::SY_BYP], s2_r[pfr_pkg::SY_BYP]);
    restart = restart | clr;
    if (ref_rise && (ref_cnt_r + 16'h0001 > ref_per_r + 16'h0001 ||
                     ref_cnt_r + 16'h0002 < ref_per_r)) begin
      restart = 1'b1;
    end
  end

  always_comb begin
    ref_cnt_nxt = ref_rise ? 16'h0000 : ref_cnt_r + 16'h0001;
    ref_per_nxt = ref_rise ? ref_cnt_r + 16'h0001 : ref_per_r;
    fb_cnt_nxt = fb_rise ? 16'h0000 : fb_cnt_r + 16'h0001;
    tick_per_nxt = tick_per_r;
    tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
    aligned_nxt = aligned_r;
    if (clr) begin
      tick_cnt_nxt = 16'h0000;
    end else if (fb_rise) begin
      aligned_nxt = ref_rise || (ref_cnt_r == 16'h0000);
      // A one-count slack keeps a phase nudge from being undone as a frequency error.
      if (fb_cnt_r > ref_per_r && tick_per_r > 16'h0001) begin
        tick_per_nxt = tick_per_r - 16'h0001;
      end else if (fb_cnt_r + 16'h0002 < ref_per_r) begin
        tick_per_nxt = tick_per_r + 16'h0001;
      end else if (!aligned_nxt && !tick) begin
        // Lagging feedback skips a count; leading feedback holds one.
        tick_cnt_nxt = (ref_cnt_r < {1'b0, ref_per_r[15:1]}) ? tick_cnt_r + 16'h0002 : tick_cnt_r;
      end
    end
  end

  always_comb begin
    stab_nxt = stab_r;
    state_nxt = state_r;
    if (restart || s2_r[pfr_pkg::SY_OEN]) begin
      stab_nxt = pfr_pkg::STAB_CYCLES[10:0];
      state_nxt = pfr_pkg::PFR_ACQUIRE;
    end else begin
      unique case (state_r)
        pfr_pkg::PFR_ACQUIRE: begin
          if (stab_r == 11'h000) begin
            state_nxt = pfr_pkg::PFR_LOCKED;
          end else begin
            stab_nxt = stab_r - 11'h001;
          end
        end
        pfr_pkg::PFR_LOCKED: begin
          state_nxt = pfr_pkg::PFR_LOCKED;
        end
      endcase
    end
  end

  always_comb begin
    refdiv_nxt = ref_rise ? ~refdiv_r : refdiv_r;
    oe_nxt = {3{~s2_r[pfr_pkg::SY_OEN]}};
    if (s2_r[pfr_pkg::SY_BYP]) begin
      b1_nxt = {3{s2_r[pfr_pkg::SY_SEL] ? refdiv_r : s2_r[pfr_pkg::SY_REF]}};
      b2_nxt = {3{s2_r[pfr_pkg::SY_REF]}};
    end else begin
      b1_nxt = {3{s2_r[pfr_pkg::SY_SEL] ? div4 : div2}};
      b2_nxt = {3{div2}};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_cnt_r <= 16'h0000;
      ref_per_r <= 16'h0000;
      fb_cnt_r <= 16'h0000;
      tick_cnt_r <= 16'h0000;
      tick_per_r <= pfr_pkg::TICK_PER_RST;
      aligned_r <= 1'b0;
      stab_r <= pfr_pkg::STAB_CYCLES[10:0];
      state_r <= pfr_pkg::PFR_ACQUIRE;
      refdiv_r <= 1'b0;
      b1_r <= 3'h0;
      b2_r <= 3'h0;
      oe_r <= 3'h0;
    end else begin
      ref_cnt_r <= ref_cnt_nxt;
      ref_per_r <= ref_per_nxt;
      fb_cnt_r <= fb_cnt_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_per_r <= tick_per_nxt;
      aligned_r <= aligned_nxt;
      stab_r <= stab_nxt;
      state_r <= state_nxt;
      refdiv_r <= refdiv_nxt;
      b1_r <= b1_nxt;
      b2_r <= b2_nxt;
      oe_r <= oe_nxt;
    end
  end

  pfr_divider u_div (
    .mclk(mclk),
    .rst(rst),
    .clear(clr),
    .tick(tick),
    .div2(div2),
    .div4(div4)
  );

  assign bank_one_clock_oe = oe_r;
  assign bank_two_clock_oe = oe_r;
  assign bank_one_clock_outputs = b1_r;
  assign bank_two_clock_outputs = b2_r;
  assign phase_locked = (state_r == pfr_pkg::PFR_LOCKED);

  drive_on_a: assert property (@(posedge mclk) disable iff (rst)
    !s2_r[pfr_pkg::SY_OEN] |=> (bank_one_clock_oe == 3'h7 && bank_two_clock_oe == 3'h7));
  float_off_a: assert property (@(posedge mclk) disable iff (rst)
    s2_r[pfr_pkg::SY_OEN] |=> (bank_one_clock_oe == 3'h0 && bank_two_clock_oe == 3'h0));
  relock_wait_a: assert property (@(posedge mclk) disable iff (rst)
    restart |=> !phase_locked [*8]);
  lock_timer_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(phase_locked) |-> ($past(stab_r) == 11'h000 && !$past(s2_r[pfr_pkg::SY_OEN])));
  settle_start_a: assert property (@(posedge mclk) disable iff (rst)
    (restart && !s2_r[pfr_pkg::SY_OEN]) |=> (stab_r == pfr_pkg::STAB_CYCLES[10:0]));
  bank_one_quarter_a: assert property (@(posedge mclk) disable iff (rst)
    (s2_r[pfr_pkg::SY_SEL] && !s2_r[pfr_pkg::SY_BYP]) |=> (b1_r == {3{$past(div4)}}));
  bank_two_half_a: assert property (@(posedge mclk) disable iff (rst)
    !s2_r[pfr_pkg::SY_BYP] |=> (b2_r == {3{$past(div2)}}));
  same_ratio_a: assert property (@(posedge mclk) disable iff (rst)
    (!s2_r[pfr_pkg::SY_SEL] && !s2_r[pfr_pkg::SY_BYP]) |=> (b1_r == b2_r));
  bypass_route_a: assert property (@(posedge mclk) disable iff (rst)
    s2_r[pfr_pkg::SY_BYP] |=> (b2_r == {3{$past(s2_r[pfr_pkg::SY_REF])}}));
  trim_floor_a: assert property (@(posedge mclk) disable iff (rst)
    fb_rise |=> (tick_per_r != 16'h0000));
  trim_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !fb_rise |=> $stable(tick_per_r));
  phase_aligned_a: assert property (@(posedge mclk) disable iff (rst)
    (phase_locked && !s2_r[pfr_pkg::SY_BYP]) |-> aligned_r);
  clear_restart_a: assert property (@(posedge mclk) disable iff (rst)
    clr |=> (!phase_locked && stab_r == pfr_pkg::STAB_CYCLES[10:0]));
  float_unlock_a: assert property (@(posedge mclk) disable iff (rst)
    s2_r[pfr_pkg::SY_OEN] |=> !phase_locked);
  bypass_ref_one_a: assert property (@(posedge mclk) disable iff (rst)
    (s2_r[pfr_pkg::SY_BYP] && !s2_r[pfr_pkg::SY_SEL]) |=>
    (b1_r == {3{$past(s2_r[pfr_pkg::SY_REF])}}));
endmodule

// ---- pfr_ref_model.sv ----
`timescale 1ns/1ps
module pfr_ref_model #(
  parameter int HALF = 8
) (
  input wire logic mclk,
  input wire logic fb_src,
  input wire logic fb_oe,
  output logic ref_clk,
  output logic fb_clk
);
  int cnt = 0;
  logic last_r = 1'b1;
  initial ref_clk = 1'b0;
  always @(negedge mclk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      ref_clk <= ~ref_clk;
    end
    if (fb_oe) begin
      last_r <= fb_src;
    end
  end
  // One output fed back.
  // A released feedback wire has no pull, so it shows the inverse of its last driven level.
  assign fb_clk = fb_oe ? fb_src : ~last_r;
endmodule

// ---- pfr_clock_fanout_bench.sv ----
`timescale 1ns/1ps
module pfr_clock_fanout_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic en_n = 1'b1;
  logic byp = 1'b0;
  logic clr = 1'b0;
  logic ref_clk;
  logic fb_clk;
  logic lock;
  logic [2:0] b1;
  logic [2:0] b1_oe;
  logic [2:0] b2;
  logic [2:0] b2_oe;
  int fail_count = 0;
  int n_compared = 0;
  int c1;
  int c2;
  int hi2;
  always #25 mclk = ~mclk;
  pfr_ref_model #(.HALF(8)) u_pfr_ref_model (.mclk(mclk), .fb_src(b2[0]), .fb_oe(b2_oe[0]),
    .ref_clk(ref_clk), .fb_clk(fb_clk));
  pfr_clock_fanout u_pfr_clock_fanout (.mclk(mclk), .rst(rst), .reference_clock_in(ref_clk),
    .feedback_clock_in(fb_clk), .ratio_select(sel), .output_enable_n(en_n),
    .loop_bypass(byp), .factory_clear_pin(clr), .bank_one_clock_outputs(b1),
    .bank_one_clock_oe(b1_oe), .bank_two_clock_outputs(b2), .bank_two_clock_oe(b2_oe),
    .phase_locked(lock));
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input string w, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", w, e, g);
    end
  endtask
  task automatic near(input string w, input int e, input int g, input int tol);
    n_compared++;
    if (g > e + tol || g < e - tol) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", w, e, g);
    end
  endtask
  task automatic pins(input logic e, input logic s, input logic b);
    @(negedge mclk);
    en_n = e;
    sel = s;
    byp = b;
  endtask
  task automatic wait_lock();
    cyc(4);
    chk("lock dropped", 4'h0, {3'h0, lock});
    cyc(986);
    chk("lock early", 4'h0, {3'h0, lock});
    cyc(20);
    chk("lock late", 4'h1, {3'h0, lock});
  endtask
  task automatic measure();
    logic p1;
    logic p2;
    c1 = 0;
    c2 = 0;
    hi2 = 0;
    p1 = b1[0];
    p2 = b2[0];
    repeat (256) begin
      @(negedge mclk);
      c1 += (b1[0] !== p1);
      c2 += (b2[0] !== p2);
      hi2 += (b2[0] === 1'b1);
      p1 = b1[0];
      p2 = b2[0];
      chk("bank bits equal", {1'b0, b1}, {1'b0, {3{b1[0]}}});
      chk("bank bits equal", {1'b0, b2}, {1'b0, {3{b2[0]}}});
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    fail_count++;
    $display("[FAIL] watchdog expected done seen hang");
    test_done();
  end
  initial begin
    cyc(20);
    rst = 1'b0;
    chk("oe at reset", 4'h0, {1'b0, b1_oe});
    chk("lock at reset", 4'h0, {3'h0, lock});
    // The reference period must be learnt first, or its early edges restart the wait.
    cyc(40);
    pins(1'b0, 1'b0, 1'b0);
    cyc(2);
    chk("oe before sync", 4'h0, {1'b0, b2_oe});
    cyc(1);
    chk("oe one", 4'h7, {1'b0, b1_oe});
    chk("oe two", 4'h7, {1'b0, b2_oe});
    wait_lock();
    $display("test enable done");
    measure();
    near("bank one equal", c2, c1, 1);
    near("bank two rate", 32, c2, 2);
    near("duty", 128, hi2, 8);
    pins(1'b0, 1'b1, 1'b0);
    wait_lock();
    measure();
    near("bank one half", c2, 2 * c1, 2);
    near("bank two rate", 32, c2, 2);
    $display("test ratio done");
    pins(1'b1, 1'b1, 1'b0);
    cyc(3);
    chk("oe off", 4'h0, {1'b0, b1_oe | b2_oe});
    chk("lock off", 4'h0, {3'h0, lock});
    pins(1'b0, 1'b1, 1'b0);
    wait_lock();
    $display("test disable done");
    @(negedge mclk);
    clr = 1'b1;
    cyc(5);
    chk("clear bank two", 4'h0, {1'b0, b2});
    chk("clear lock", 4'h0, {3'h0, lock});
    clr = 1'b0;
    wait_lock();
    $display("test clear done");
    pins(1'b0, 1'b1, 1'b1);
    cyc(4);
    measure();
    near("bypass two", 32, c2, 1);
    near("bypass one", 16, c1, 1);
    pins(1'b0, 1'b0, 1'b1);
    cyc(4);
    measure();
    near("bypass one ref", 32, c1, 1);
    pins(1'b0, 1'b0, 1'b0);
    wait_lock();
    $display("test bypass done");
    test_done();
  end
endmodule
